// ### core/caes_cfg.svh
// Offsets, field positions, reset values and timing for the action/event block.
// Assumes inclusion by bare name from caes_pkg.sv and caes_top.sv.
`ifndef CAES_CFG_SVH
`define CAES_CFG_SVH
`define CAES_AW             8
`define CAES_REG_CTRL       8'h00
`define CAES_REG_EVT_SEL    8'h04
`define CAES_REG_EVT_EN     8'h08
`define CAES_REG_META_SEL   8'h0C
`define CAES_REG_META_EN    8'h10
`define CAES_REG_DEV_KEY    8'h14
`define CAES_REG_GRP_KEY    8'h18
`define CAES_REG_GRP_MASK   8'h1C
`define CAES_REG_ACT_IDX    8'h20
`define CAES_REG_Q_DEPTH    8'h24
`define CAES_REG_STATUS     8'h28
`define CAES_REG_TSCAP_LO   8'h2C
`define CAES_REG_TSCAP_HI   8'h30
`define CAES_CTRL_META      0
`define CAES_CTRL_PTP       1
`define CAES_CTRL_LATCH     2
`define CAES_CTRL_TSRST     3
`define CAES_ST_READY       0
`define CAES_ST_SYNCED      1
`define CAES_ST_MASTER      2
`define CAES_ST_QCNT        4
`define CAES_N_EVT          11
`define CAES_N_META         13
`define CAES_Q_DEPTH        4
`define CAES_ACT_IDX        32'h0000_0000
`define CAES_EVT_ID_BASE    16'h9000
`define CAES_OWN_QUALITY    8'h80
`define CAES_RESP_OK        2'b00
`define CAES_RESP_ERR       2'b10
`define CAES_CLK_PERIOD_NS  5
`define CAES_SYNC_PERIOD_US 1000000
`define CAES_LISTEN_US      3000
`define CAES_SYNC_CYC       ((`CAES_SYNC_PERIOD_US * 1000) / `CAES_CLK_PERIOD_NS)
`define CAES_LISTEN_CYC     ((`CAES_LISTEN_US * 1000) / `CAES_CLK_PERIOD_NS)
`endif

// ### core/caes_pkg.sv
// Types carried between the action/event block and its neighbours.
// Assumes caes_cfg.svh sits on the include path.
`include "caes_cfg.svh"
package caes_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] device_key;
    logic [31:0] group_key;
    logic [31:0] group_mask;
    logic        has_ts;
    logic [63:0] ts;
  } caes_act_cmd_t;
  typedef struct packed {
    logic        valid;
    logic [63:0] t1;
    logic [63:0] t2;
    logic [63:0] t3;
    logic [63:0] t4;
  } caes_sync_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  quality;
    logic [47:0] mac;
  } caes_announce_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] id;
    logic [63:0] ts;
  } caes_evt_msg_t;
  typedef enum logic [3:0] {
    CAES_PTP_OFF    = 4'b0001,
    CAES_PTP_LISTEN = 4'b0010,
    CAES_PTP_SLAVE  = 4'b0100,
    CAES_PTP_MASTER = 4'b1000
  } caes_ptp_st_t;
endpackage : caes_pkg

// ### core/caes_top.sv
// Action command filter and scheduler, event notifier, metadata selector and PTP clock.
// Assumes one 200 MHz clock, synchronous reset, AXI4-Lite master, same-clock camera events.
//
// What this block does
// - Eleven event sources: action late, trigger, exposure, frame, discard, line edges.
// - Selected source notifies only while its notify enable is on.
// - Enabled events leave as event messages toward the control channel.
// - Global metadata attach switch, off after reset, drops attach and zeroes the item mask taken at each later exposure start.
// - Each metadata item has its own enable, reached through an item selector.
// - Enabled item mask and time are frozen at exposure start per frame.
// - Single action slot; command index always reads zero.
// - Command group key must equal group_match_key.
// - Command mask AND group_match_mask must have a bit set.
// - Commands timestamped in the future wait in a queue; its depth is readable.
// - Queued command starts exposure when the clock reaches its timestamp.
// - Command without timestamp starts exposure at once.
// - With precision time on, commands are taken only once synchronised or while master.
// - Timekeeping follows PTP version 2 offset and delay arithmetic.
// - Best-master selection picks the best clock quality seen.
// - Equal quality ties go to the smallest MAC address.
// - Offset from four timestamps corrects the local clock, removing path delay.
// - Slave requests a new exchange periodically to correct drift.
// - Capture command latches the counter; reset command clears it.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "caes_cfg.svh"
module caes_top
  import caes_pkg::*;
#(
  parameter int unsigned SYNC_CYC   = `CAES_SYNC_CYC,
  parameter int unsigned LISTEN_CYC = `CAES_LISTEN_CYC
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`CAES_AW-1:0]    s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [`CAES_AW-1:0]    s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  input  wire caes_act_cmd_t          act_cmd_i,
  input  wire caes_sync_t             sync_i,
  input  wire caes_announce_t         announce_i,
  input  wire logic [47:0]            mac_addr_i,
  input  wire logic [5:0]             cam_evt_i,
  input  wire logic                   line0_i,
  input  wire logic                   line2_i,
  input  wire logic                   evt_ready_i,
  output caes_evt_msg_t               evt_msg_o,
  output logic                        act_expose_o,
  output logic                        delay_req_o,
  output logic                        meta_attach_o,
  output logic [`CAES_N_META-1:0]     meta_mask_o,
  output logic [63:0]                 meta_ts_o,
  output logic [63:0]                 ts_o
);
  localparam int QW = $clog2(`CAES_Q_DEPTH + 1);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Control registers
  logic                    meta_master_q;
  logic                    ptp_en_q;
  logic [3:0]              evt_sel_q;
  logic [3:0]              meta_sel_q;
  logic [`CAES_N_EVT-1:0]  notify_en_q;
  logic [`CAES_N_META-1:0] meta_en_q;
  logic [31:0]             dev_key_q;
  logic [31:0]             grp_key_q;
  logic [31:0]             grp_mask_q;
  logic [63:0]             ts_q;
  logic [63:0]             ts_cap_q;
  // AXI state
  logic                    aw_got_q;
  logic                    w_got_q;
  logic [`CAES_AW-1:0]     awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    we;
  logic                    wmap;
  logic [31:0]             rdata_d;
  logic                    rmap;
  // PTP
  caes_ptp_st_t            ptp_q;
  logic                    synced_q;
  logic [31:0]             tmr_q;
  logic                    peer_better;
  logic signed [63:0]      offset;
  logic                    ready;
  // Action queue
  logic [`CAES_Q_DEPTH-1:0] qv_q;
  logic [63:0]              qts_q [`CAES_Q_DEPTH];
  logic [`CAES_Q_DEPTH-1:0] fire;
  logic [`CAES_Q_DEPTH-1:0] free_oh;
  logic [QW-1:0]            qcnt;
  logic                     accept;
  logic                     load;
  logic                     immediate;
  logic                     late_q;
  // Events
  logic [1:0]               l_s1_q;
  logic [1:0]               l_s2_q;
  logic [1:0]               l_s3_q;
  logic [`CAES_N_EVT-1:0]   evt_vec;
  logic [`CAES_N_EVT-1:0]   pend_q;
  logic [`CAES_N_EVT-1:0]   take_oh;
  logic [3:0]               take_idx;
  logic                     take;

  // Write side: address and data taken in either order
  assign we   = aw_got_q & w_got_q & ~s_axi_bvalid_o;
  assign wmap = (awaddr_q == `CAES_REG_CTRL)     || (awaddr_q == `CAES_REG_EVT_SEL)  ||
                (awaddr_q == `CAES_REG_EVT_EN)   || (awaddr_q == `CAES_REG_META_SEL) ||
                (awaddr_q == `CAES_REG_META_EN)  || (awaddr_q == `CAES_REG_DEV_KEY)  ||
                (awaddr_q == `CAES_REG_GRP_KEY)  || (awaddr_q == `CAES_REG_GRP_MASK);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_got_q        <= 1'b0;
      w_got_q         <= 1'b0;
      awaddr_q        <= '0;
      wdata_q         <= '0;
      wstrb_q         <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `CAES_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_q        <= 1'b1;
        awaddr_q        <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_q        <= 1'b1;
        wdata_q        <= s_axi_wdata_i;
        wstrb_q        <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (we) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wmap ? `CAES_RESP_OK : `CAES_RESP_ERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        aw_got_q        <= 1'b0;
        w_got_q         <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_master_q <= 1'b0;
      ptp_en_q      <= 1'b0;
      evt_sel_q     <= '0;
      meta_sel_q    <= '0;
      notify_en_q   <= '0;
      meta_en_q     <= '0;
      dev_key_q     <= '0;
      grp_key_q     <= '0;
      grp_mask_q    <= '0;
    end else if (we && wstrb_q[0]) begin
      case (awaddr_q)
        `CAES_REG_CTRL: begin
          meta_master_q <= wdata_q[`CAES_CTRL_META];
          ptp_en_q      <= wdata_q[`CAES_CTRL_PTP];
        end
        `CAES_REG_EVT_SEL:  evt_sel_q  <= wdata_q[3:0];
        `CAES_REG_META_SEL: meta_sel_q <= wdata_q[3:0];
        `CAES_REG_EVT_EN: begin
          if (evt_sel_q < 4'(`CAES_N_EVT)) notify_en_q[evt_sel_q] <= wdata_q[0];
        end
        `CAES_REG_META_EN: begin
          if (meta_sel_q < 4'(`CAES_N_META)) meta_en_q[meta_sel_q] <= wdata_q[0];
        end
        `CAES_REG_DEV_KEY:  dev_key_q  <= merge(dev_key_q, wdata_q, wstrb_q);
        `CAES_REG_GRP_KEY:  grp_key_q  <= merge(grp_key_q, wdata_q, wstrb_q);
        `CAES_REG_GRP_MASK: grp_mask_q <= merge(grp_mask_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end else if (we) begin
      case (awaddr_q)
        `CAES_REG_DEV_KEY:  dev_key_q  <= merge(dev_key_q, wdata_q, wstrb_q);
        `CAES_REG_GRP_KEY:  grp_key_q  <= merge(grp_key_q, wdata_q, wstrb_q);
        `CAES_REG_GRP_MASK: grp_mask_q <= merge(grp_mask_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Read side: answer one cycle after the address is taken
  always_comb begin
    rdata_d = '0;
    rmap    = 1'b1;
    case (s_axi_araddr_i)
      `CAES_REG_CTRL: begin
        rdata_d[`CAES_CTRL_META] = meta_master_q;
        rdata_d[`CAES_CTRL_PTP]  = ptp_en_q;
      end
      `CAES_REG_EVT_SEL:  rdata_d[3:0] = evt_sel_q;
      `CAES_REG_META_SEL: rdata_d[3:0] = meta_sel_q;
      `CAES_REG_EVT_EN:
        rdata_d[0] = (evt_sel_q < 4'(`CAES_N_EVT)) ? notify_en_q[evt_sel_q] : 1'b0;
      `CAES_REG_META_EN:
        rdata_d[0] = (meta_sel_q < 4'(`CAES_N_META)) ? meta_en_q[meta_sel_q] : 1'b0;
      `CAES_REG_DEV_KEY:  rdata_d = dev_key_q;
      `CAES_REG_GRP_KEY:  rdata_d = grp_key_q;
      `CAES_REG_GRP_MASK: rdata_d = grp_mask_q;
      `CAES_REG_ACT_IDX:  rdata_d = `CAES_ACT_IDX;
      `CAES_REG_Q_DEPTH:  rdata_d = 32'(`CAES_Q_DEPTH);
      `CAES_REG_STATUS: begin
        rdata_d[`CAES_ST_READY]  = ready;
        rdata_d[`CAES_ST_SYNCED] = synced_q;
        rdata_d[`CAES_ST_MASTER] = (ptp_q == CAES_PTP_MASTER);
        rdata_d[`CAES_ST_QCNT +: QW] = qcnt;
      end
      `CAES_REG_TSCAP_LO: rdata_d = ts_cap_q[31:0];
      `CAES_REG_TSCAP_HI: rdata_d = ts_cap_q[63:32];
      default:            rmap = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= `CAES_RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rdata_d;
      s_axi_rresp_o   <= rmap ? `CAES_RESP_OK : `CAES_RESP_ERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Time counter; reset command beats a correction in the same cycle
  assign offset = (signed'(sync_i.t2 - sync_i.t1) - signed'(sync_i.t4 - sync_i.t3)) >>> 1;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ts_q     <= '0;
      ts_cap_q <= '0;
    end else begin
      if (we && wstrb_q[0] && awaddr_q == `CAES_REG_CTRL && wdata_q[`CAES_CTRL_TSRST]) begin
        ts_q <= '0;
      end else if (sync_i.valid && ptp_q == CAES_PTP_SLAVE) begin
        ts_q <= ts_q + 64'(`CAES_CLK_PERIOD_NS) - 64'(offset);
      end else begin
        ts_q <= ts_q + 64'(`CAES_CLK_PERIOD_NS);
      end
      if (we && wstrb_q[0] && awaddr_q == `CAES_REG_CTRL && wdata_q[`CAES_CTRL_LATCH]) begin
        ts_cap_q <= ts_q;
      end
    end
  end

  // Best master: lower quality value wins, then lower MAC
  assign peer_better = announce_i.valid &&
                       ((announce_i.quality < `CAES_OWN_QUALITY) ||
                        (announce_i.quality == `CAES_OWN_QUALITY &&
                         announce_i.mac < mac_addr_i));
  assign ready = ~ptp_en_q || (ptp_q == CAES_PTP_MASTER) || synced_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptp_q       <= CAES_PTP_OFF;
      synced_q    <= 1'b0;
      tmr_q       <= '0;
      delay_req_o <= 1'b0;
    end else begin
      delay_req_o <= 1'b0;
      if (!ptp_en_q) begin
        ptp_q    <= CAES_PTP_OFF;
        synced_q <= 1'b0;
      end else begin
        case (ptp_q)
          CAES_PTP_OFF: begin
            ptp_q <= CAES_PTP_LISTEN;
            tmr_q <= LISTEN_CYC;
          end
          CAES_PTP_LISTEN: begin
            if (peer_better) begin
              ptp_q       <= CAES_PTP_SLAVE;
              tmr_q       <= SYNC_CYC;
              delay_req_o <= 1'b1;
            end else if (tmr_q == '0) begin
              ptp_q <= CAES_PTP_MASTER;
            end else begin
              tmr_q <= tmr_q - 32'd1;
            end
          end
          CAES_PTP_SLAVE: begin
            if (sync_i.valid) synced_q <= 1'b1;
            if (tmr_q == '0) begin
              tmr_q       <= SYNC_CYC;
              delay_req_o <= 1'b1;
            end else begin
              tmr_q <= tmr_q - 32'd1;
            end
          end
          CAES_PTP_MASTER: begin
            // Lost master role must resync before commands count as aligned
            if (peer_better) begin
              ptp_q       <= CAES_PTP_SLAVE;
              synced_q    <= 1'b0;
              tmr_q       <= SYNC_CYC;
              delay_req_o <= 1'b1;
            end
          end
          default: ptp_q <= CAES_PTP_OFF;
        endcase
      end
    end
  end

  // Action command filter
  assign accept = act_cmd_i.valid && ready &&
                  (act_cmd_i.device_key == dev_key_q) &&
                  (act_cmd_i.group_key == grp_key_q) &&
                  |(act_cmd_i.group_mask & grp_mask_q);
  // Past-due timestamp fires at once and flags action late
  assign immediate = accept && (!act_cmd_i.has_ts || act_cmd_i.ts <= ts_q);
  assign load      = accept && act_cmd_i.has_ts && act_cmd_i.ts > ts_q;

  always_comb begin
    free_oh = '0;
    qcnt    = '0;
    for (int e = `CAES_Q_DEPTH - 1; e >= 0; e--) begin
      if (!qv_q[e]) free_oh = `CAES_Q_DEPTH'(1) << e;
    end
    for (int e = 0; e < `CAES_Q_DEPTH; e++) begin
      qcnt = qcnt + QW'(qv_q[e]);
    end
  end

  // Full queue drops the command silently
  for (genvar e = 0; e < `CAES_Q_DEPTH; e++) begin : g_q
    assign fire[e] = qv_q[e] && (qts_q[e] <= ts_q);
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        qv_q[e]  <= 1'b0;
        qts_q[e] <= '0;
      end else if (fire[e]) begin
        qv_q[e] <= 1'b0;
      end else if (load && free_oh[e]) begin
        qv_q[e]  <= 1'b1;
        qts_q[e] <= act_cmd_i.ts;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      act_expose_o <= 1'b0;
      late_q       <= 1'b0;
    end else begin
      act_expose_o <= immediate || |fire;
      late_q       <= immediate && act_cmd_i.has_ts;
    end
  end

  // Line pins: two-flop synchronisers, edges taken after the second
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      l_s1_q <= '0;
      l_s2_q <= '0;
      l_s3_q <= '0;
    end else begin
      l_s1_q <= {line2_i, line0_i};
      l_s2_q <= l_s1_q;
      l_s3_q <= l_s2_q;
    end
  end

  assign evt_vec = {~l_s2_q[1] & l_s3_q[1], l_s2_q[1] & ~l_s3_q[1],
                    ~l_s2_q[0] & l_s3_q[0], l_s2_q[0] & ~l_s3_q[0],
                    cam_evt_i, late_q};

  always_comb begin
    take_oh = '0;
    for (int i = `CAES_N_EVT - 1; i >= 0; i--) begin
      if (pend_q[i]) take_oh = `CAES_N_EVT'(1) << i;
    end
    take_idx = '0;
    for (int i = 0; i < `CAES_N_EVT; i++) begin
      if (take_oh[i]) take_idx = 4'(i);
    end
  end
  assign take = |pend_q && (!evt_msg_o.valid || evt_ready_i);

  // New event wins over the clear of its own pending bit
  for (genvar i = 0; i < `CAES_N_EVT; i++) begin : g_ev
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        pend_q[i] <= 1'b0;
      end else if (evt_vec[i] && notify_en_q[i]) begin
        pend_q[i] <= 1'b1;
      end else if (take && take_oh[i]) begin
        pend_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      evt_msg_o <= '0;
    end else if (take) begin
      evt_msg_o.valid <= 1'b1;
      evt_msg_o.id    <= `CAES_EVT_ID_BASE + 16'(take_idx);
      evt_msg_o.ts    <= ts_q;
    end else if (evt_ready_i) begin
      evt_msg_o.valid <= 1'b0;
    end
  end

  // Metadata frozen at exposure start so later changes miss this frame
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_attach_o <= 1'b0;
      meta_mask_o   <= '0;
      meta_ts_o     <= '0;
      ts_o          <= '0;
    end else begin
      meta_attach_o <= meta_master_q;
      ts_o          <= ts_q;
      if (cam_evt_i[1]) begin
        meta_mask_o <= meta_master_q ? meta_en_q : '0;
        meta_ts_o   <= ts_q;
      end
    end
  end
endmodule : caes_top
`default_nettype wire

// ### verification/caes_monitor.sv
// Port checker for the action/event block, bound into the design from the bench.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "caes_cfg.svh"
module caes_monitor
  import caes_pkg::*;
(
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire logic [`CAES_AW-1:0] s_axi_araddr_i,
  input wire logic                s_axi_arvalid_i,
  input wire logic                s_axi_arready_o,
  input wire logic                s_axi_wvalid_i,
  input wire logic [31:0]         s_axi_rdata_o,
  input wire caes_sync_t          sync_i,
  input wire logic [5:0]          cam_evt_i,
  input wire logic                evt_ready_i,
  input wire caes_evt_msg_t       evt_msg_o,
  input wire logic                act_expose_o,
  input wire logic                delay_req_o,
  input wire logic                meta_attach_o,
  input wire logic [12:0]         meta_mask_o,
  input wire logic [63:0]         ts_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  q_depth_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == `CAES_REG_Q_DEPTH |=> s_axi_rdata_o == 32'h4) else $error("depth wrong");
  meta_off_a: assert property (!meta_attach_o ##1 !meta_attach_o
    |-> meta_mask_o == 13'h0) else $error("metadata while off");
  meta_hold_a: assert property (meta_attach_o && !cam_evt_i[1] ##1 meta_attach_o
    |-> $stable(meta_mask_o)) else $error("mask moved between exposures");
  evt_hold_a: assert property (evt_msg_o.valid && !evt_ready_i
    |=> evt_msg_o.valid && $stable(evt_msg_o)) else $error("event dropped early");
  evt_id_a: assert property (evt_msg_o.valid
    |-> evt_msg_o.id - 16'h9000 < 16'hB) else $error("event id out of range");
  // Writes and syncs may move time, so only quiet stretches are judged
  time_run_a: assert property ((!sync_i.valid && !s_axi_wvalid_i) [*4]
    |=> ts_o == $past(ts_o) + 64'h5) else $error("time step wrong");
  sync_req_a: assert property (delay_req_o
    |=> !delay_req_o [*8] ##[1:60] delay_req_o) else $error("resync not periodic");
  expose_pulse_a: assert property (act_expose_o |=> !act_expose_o)
    else $error("exposure pulse too long");
endmodule : caes_monitor
`default_nettype wire

// ### verification/caes_peer.sv
// Network-side model: a PTP master that announces and answers delay requests.
// Assumes the device clock and reset; timestamps are in nanoseconds.
`timescale 1ns/1ps
`default_nettype none
module caes_peer
  import caes_pkg::*;
(
  input  wire logic     ref_clk_i,
  input  wire logic     rst_i,
  input  wire logic     delay_req_i,
  output caes_announce_t announce_o,
  output caes_sync_t    sync_o
);
  logic [3:0] tick_q;
  logic [1:0] wait_q;
  always_ff @(posedge ref_clk_i) begin
    tick_q <= rst_i ? 4'h0 : tick_q + 4'h1;
  end
  // Equal quality, smaller address: wins on the tie-break only
  always_ff @(posedge ref_clk_i) begin
    announce_o <= '{tick_q == 4'hF, 8'h80, 48'h0};
  end
  always_ff @(posedge ref_clk_i) begin
    wait_q <= rst_i ? 2'h0 : delay_req_i ? 2'h3 : wait_q - 2'(wait_q != 2'h0);
  end
  // Path delay 1000 ns, local clock 100 ns ahead
  always_ff @(posedge ref_clk_i) begin
    sync_o <= '{wait_q == 2'h1, 64'h0, 64'h44C, 64'h7D0, 64'hB54};
  end
endmodule : caes_peer
`default_nettype wire

// ### verification/tb_camera_action_event_sync.sv
// Bench for the action/event block: AXI4-Lite tasks and rule scenarios.
// Assumes block, package, checker and network model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "caes_cfg.svh"
module tb_camera_action_event_sync
  import caes_pkg::*;
;
  logic ref_clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, line0_i, line2_i, evt_ready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, act_expose_o, delay_req_o, meta_attach_o;
  logic [7:0]     s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]    s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0]     s_axi_wstrb_i;
  logic [1:0]     s_axi_bresp_o, s_axi_rresp_o;
  logic [5:0]     cam_evt_i;
  logic [47:0]    mac_addr_i;
  logic [12:0]    meta_mask_o;
  logic [63:0]    meta_ts_o, ts_o;
  caes_act_cmd_t  act_cmd_i;
  caes_sync_t     sync_i;
  caes_announce_t announce_i;
  caes_evt_msg_t  evt_msg_o;
  int             bad_count, n_compared, k;
  caes_top #(.SYNC_CYC(50), .LISTEN_CYC(20)) i_caes_top (.*);
  caes_peer i_caes_peer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .delay_req_i(delay_req_o),
    .announce_o(announce_i), .sync_o(sync_i));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    check(s_axi_bresp_o, 2'b00, "bresp");
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                      input string what);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    rd = s_axi_rdata_o;
    check(s_axi_rresp_o, r, what);
    if (a != `CAES_REG_TSCAP_LO) check(rd, d, what);
  endtask : rchk
  task automatic act(input logic [31:0] dk, gk, gm, input logic h, input logic [63:0] t);
    act_cmd_i <= '{1'b1, dk, gk, gm, h, t};
    @(posedge ref_clk_i);
    act_cmd_i <= '{1'b0, ~dk, ~gk, ~gm, ~h, ~t};
  endtask : act
  task automatic ev(input logic [15:0] id);
    k = 0;
    while (evt_msg_o.valid !== 1'b1 && k < 20) begin
      @(posedge ref_clk_i);
      k++;
    end
    check(evt_msg_o.id, id, "event id");
    evt_ready_i <= 1'b1;
    @(posedge ref_clk_i);
    evt_ready_i <= 1'b0;
  endtask : ev
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run is under a thousand cycles; allow ten thousand
  initial begin
    #50000;
    bad_count++;
    end_of_test;
  end
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h05;
    {line0_i, line2_i, evt_ready_i, cam_evt_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
    {s_axi_wdata_i, act_cmd_i, bad_count, n_compared} = '0;
    s_axi_wstrb_i = 4'hF;
    mac_addr_i = 48'h10;
    rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(`CAES_REG_CTRL, 32'h0, 2'b00, "ctrl");
    rchk(`CAES_REG_ACT_IDX, 32'h0, 2'b00, "index");
    rchk(`CAES_REG_Q_DEPTH, 32'h4, 2'b00, "depth");
    rchk(8'h3C, 32'h0, 2'b10, "unmapped");
    wr(`CAES_REG_DEV_KEY, 32'h11);
    wr(`CAES_REG_GRP_KEY, 32'h22);
    wr(`CAES_REG_GRP_MASK, 32'h0F);
    for (int i = 0; i < 4; i++) begin
      act(i == 1 ? 32'h12 : 32'h11, i == 2 ? 32'h23 : 32'h22, i == 3 ? 32'hF0 : 32'h81, 1'b0,
          64'h0);
      @(posedge ref_clk_i);
      check(act_expose_o, 64'(i == 0), "expose");
    end
    wr(`CAES_REG_EVT_SEL, 32'h0);
    wr(`CAES_REG_EVT_EN, 32'h1);
    act(32'h11, 32'h22, 32'h1, 1'b1, 64'h0);
    @(posedge ref_clk_i);
    check(act_expose_o, 1'b1, "late expose");
    ev(16'h9000);
    wr(`CAES_REG_CTRL, 32'h8);
    act(32'h11, 32'h22, 32'h1, 1'b1, 64'd2000);
    rchk(`CAES_REG_STATUS, 32'h11, 2'b00, "queued");
    k = 0;
    while (act_expose_o !== 1'b1 && k < 500) begin
      @(posedge ref_clk_i);
      k++;
    end
    check(k > 370 && k < 400, 1'b1, "scheduled");
    wr(`CAES_REG_CTRL, 32'h8);
    wr(`CAES_REG_CTRL, 32'h4);
    rchk(`CAES_REG_TSCAP_LO, 32'h0, 2'b00, "latch lo");
    check(rd > 0 && rd <= 30, 1'b1, "latch lo");
    rchk(`CAES_REG_TSCAP_HI, 32'h0, 2'b00, "latch hi");
    for (int i = 1; i <= 10; i++) begin
      wr(`CAES_REG_EVT_SEL, 32'(i));
      wr(`CAES_REG_EVT_EN, 32'h1);
      if (i <= 6) cam_evt_i <= 6'h1 << (i - 1);
      else if (i <= 8) line0_i <= i == 7;
      else line2_i <= i == 9;
      @(posedge ref_clk_i);
      cam_evt_i <= 6'h0;
      ev(16'h9000 + 16'(i));
    end
    wr(`CAES_REG_EVT_SEL, 32'h9);
    wr(`CAES_REG_EVT_EN, 32'h0);
    line2_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    check(evt_msg_o.valid, 1'b0, "muted");
    wr(`CAES_REG_META_SEL, 32'h6);
    wr(`CAES_REG_META_EN, 32'h1);
    wr(`CAES_REG_CTRL, 32'h1);
    cam_evt_i <= 6'h2;
    @(posedge ref_clk_i);
    cam_evt_i <= 6'h0;
    @(posedge ref_clk_i);
    check(meta_attach_o, 1'b1, "attach");
    check(meta_mask_o, 13'h40, "mask");
    check(meta_ts_o, ts_o, "meta time");
    ev(16'h9002);
    wr(`CAES_REG_CTRL, 32'h3);
    act(32'h11, 32'h22, 32'h1, 1'b0, 64'h0);
    @(posedge ref_clk_i);
    check(act_expose_o, 1'b0, "unsynced");
    repeat (40) @(posedge ref_clk_i);
    rchk(`CAES_REG_STATUS, 32'h3, 2'b00, "synced");
    act(32'h11, 32'h22, 32'h1, 1'b0, 64'h0);
    @(posedge ref_clk_i);
    check(act_expose_o, 1'b1, "synced expose");
    repeat (150) @(posedge ref_clk_i);
    end_of_test;
  end
endmodule : tb_camera_action_event_sync
bind caes_top caes_monitor i_caes_monitor (.*);
`default_nettype wire
